// File: mbf_framer.sv
// Modbus master request framer with APB registers and float handling
//
// Summary of operation
// - Only codes 1,2,3,4,5,6,15,16 issued
// - Remote start location goes into address field
// - Addresses above 7000 hold float values
// - Float count means values of two words
// - Real enable makes each value four bytes
// - FC16 doubles byte count when base <= start
// - Base above start: plain two-byte values
// - Float handling only for codes 6, 16
// - Float quantity counts 32-bit values
// - Write data fetched from local table offset
// - Byte and word order per swap select
// - FC16 frame: node, code, addr, qty, count, data
// - Float keeps quantity, doubles byte count
// - Swap 0 none, 1 words, 2 all, 3 bytes
// - Quantity limited 125 words, 800 bits
// - Poll interval gap between consecutive issues
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mbf_framer
  import mbf_pkg::*;
#(
  parameter int AW         = 10,
  parameter int CYC_PER_MS = mbf_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Transmit byte stream
  output var  logic [7:0]  tx_data,
  output var  logic        tx_valid,
  output var  logic        tx_last,
  input  wire logic        tx_ready,
  // Response byte stream
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_end,
  // Status
  output var  logic        frame_busy
);

  import mbf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mbf_state_e    state;
    logic [7:0]    slave;
    logic [7:0]    func;
    logic [15:0]   start;
    logic [15:0]   qty;
    logic [15:0]   loc_off;
    logic [1:0]    swap;
    logic          float_en;
    logic          cont;
    logic [15:0]   float_base;
    logic [15:0]   poll_ms;
    logic [15:0]   tbl_idx;
    logic          pending;
    logic          busy;
    logic          float_act;
    logic          err_func;
    logic          err_qty;
    logic          rx_ok;
    logic          rx_bad;
    logic [19:0]   ptr;
    logic [15:0]   vcnt;
    logic [1:0]    bidx;
    logic [15:0]   w0;
    logic [15:0]   w1;
    logic [AW-1:0] rd_addr;
    logic [15:0]   crc;
    logic [15:0]   rx_crc;
    logic [7:0]    tx_data;
    logic          tx_valid;
    logic          tx_last;
    logic [14:0]   div;
    logic [15:0]   poll_cnt;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [15:0]   wr_data;
  } mbf_regs_s;

  mbf_regs_s st;
  mbf_regs_s next_st;

  logic [15:0] rd_data;
  logic        slot;
  logic        go;
  logic [7:0]  bval;
  logic        fc_legal;
  logic        fc_bit;
  logic        fc_read;
  logic        fc_single;
  logic [7:0]  bc_calc;
  logic [1:0]  nb_last;
  logic [31:0] val32;
  logic [31:0] pair_sh;
  logic        qty_ok;

  localparam logic [14:0] DIV_TOP = 15'(CYC_PER_MS - 1);

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd

  function automatic logic [31:0] swap32(input logic [1:0] code, input logic [31:0] x);
    case (code)
      2'd1:    return {x[15:0], x[31:16]};
      2'd2:    return {x[7:0], x[15:8], x[23:16], x[31:24]};
      2'd3:    return {x[23:16], x[31:24], x[7:0], x[15:8]};
      default: return x;
    endcase
  endfunction : swap32

  mbf_table_ram #(.AW(AW), .DW(16)) u_table (
    .clk     (pclk),
    .wr_en   (st.wr_en),
    .wr_addr (st.wr_addr),
    .wr_data (st.wr_data),
    .rd_addr (st.rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    fc_legal  = st.func inside {FC_RD_COIL, FC_RD_INP, FC_RD_HOLD, FC_RD_IREG,
                                FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS};
    fc_bit    = st.func inside {FC_RD_COIL, FC_RD_INP, FC_WR_COIL, FC_WR_COILS};
    fc_read   = st.func inside {FC_RD_COIL, FC_RD_INP, FC_RD_HOLD, FC_RD_IREG};
    fc_single = st.func inside {FC_WR_COIL, FC_WR_REG};
    qty_ok    = fc_single || (st.qty != 16'd0 &&
                st.qty <= (fc_bit ? MAX_BITS : MAX_WORDS));
    if (fc_bit)
      bc_calc = 8'((st.qty + 16'd7) >> 3);
    else if (st.float_act)
      bc_calc = 8'(st.qty << 2);
    else
      bc_calc = 8'(st.qty << 1);
    nb_last = st.float_act ? 2'd3 : (st.func == FC_WR_COILS ? 2'd0 : 2'd1);
    pair_sh = {st.w1, st.w0} >> st.ptr[3:0];
    if (st.float_act)
      val32 = swap32(st.swap, {st.w0, st.w1});
    else if (st.func == FC_WR_COIL)
      val32 = {(pair_sh[0] ? COIL_ON : 16'h0000), 16'h0000};
    else if (st.func == FC_WR_COILS)
      val32 = {pair_sh[7:0], 24'h000000};
    else
      val32 = {(st.swap[1] ? {st.w0[7:0], st.w0[15:8]} : st.w0), 16'h0000};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    go      = 1'b0;
    bval    = 8'h00;
    slot    = !st.tx_valid || tx_ready;

    // APB access: answer one cycle into the access phase
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.wr_en   = 1'b0;
    if (psel && penable && !st.pready)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CTRL:      next_st.prdata = {22'h0, st.swap, 3'h0, st.float_en, 2'h0, st.cont, 1'b0};
        OFS_NODE_FUNC: next_st.prdata = {16'h0, st.func, st.slave};
        OFS_START:     next_st.prdata = {16'h0, st.start};
        OFS_QTY:       next_st.prdata = {16'h0, st.qty};
        OFS_LOC_OFF:   next_st.prdata = {16'h0, st.loc_off};
        OFS_FLT_BASE:  next_st.prdata = {16'h0, st.float_base};
        OFS_POLL:      next_st.prdata = {16'h0, st.poll_ms};
        OFS_STATUS:    next_st.prdata = {27'h0, st.rx_bad, st.rx_ok, st.err_qty,
                                         st.err_func, st.busy};
        OFS_TBL_IDX:   next_st.prdata = {16'h0, st.tbl_idx};
        OFS_TBL_DATA:  next_st.prdata = 32'h0000_0000;
        default:       next_st.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && st.pready && pwrite)
    begin
      // Configuration other than the poll interval is frozen while a frame is on its way out
      case (paddr)
        OFS_CTRL:
        begin
          if (!st.busy)
          begin
            next_st.cont     = pwdata[CTRL_CONT_BIT];
            next_st.float_en = pwdata[CTRL_FLT_BIT];
            next_st.swap     = pwdata[CTRL_SWAP_LSB +: 2];
          end
          if (pwdata[CTRL_START_BIT])
            next_st.pending = 1'b1;
        end
        OFS_NODE_FUNC:
        begin
          if (!st.busy)
          begin
            next_st.slave = pwdata[7:0];
            next_st.func  = pwdata[NF_FUNC_LSB +: 8];
          end
        end
        OFS_START:    if (!st.busy) next_st.start = pwdata[15:0];
        OFS_QTY:      if (!st.busy) next_st.qty = pwdata[15:0];
        OFS_LOC_OFF:  if (!st.busy) next_st.loc_off = pwdata[15:0];
        OFS_FLT_BASE: if (!st.busy) next_st.float_base = pwdata[15:0];
        OFS_POLL:     next_st.poll_ms = pwdata[15:0];
        OFS_STATUS:
        begin
          if (pwdata[ST_EFUNC_BIT]) next_st.err_func = 1'b0;
          if (pwdata[ST_EQTY_BIT])  next_st.err_qty = 1'b0;
          if (pwdata[ST_RXOK_BIT])  next_st.rx_ok = 1'b0;
          if (pwdata[ST_RXBAD_BIT]) next_st.rx_bad = 1'b0;
        end
        OFS_TBL_IDX:  next_st.tbl_idx = pwdata[15:0];
        OFS_TBL_DATA:
        begin
          next_st.wr_en   = 1'b1;
          next_st.wr_addr = st.tbl_idx[AW-1:0];
          next_st.wr_data = pwdata[15:0];
          next_st.tbl_idx = st.tbl_idx + 16'd1;
        end
        default: ;
      endcase
    end

    if (st.tx_valid && tx_ready)
    begin
      next_st.tx_valid = 1'b0;
      next_st.tx_last  = 1'b0;
    end

    if (st.poll_cnt != 16'd0)
    begin
      next_st.div = (st.div == 15'd0) ? DIV_TOP : st.div - 15'd1;
      if (st.div == 15'd0)
        next_st.poll_cnt = st.poll_cnt - 16'd1;
    end

    case (st.state)
      S_IDLE:
      begin
        if (st.pending && st.poll_cnt == 16'd0)
        begin
          next_st.pending = 1'b0;
          if (!fc_legal)
            next_st.err_func = 1'b1;
          else if (!qty_ok)
            next_st.err_qty = 1'b1;
          else
          begin
            next_st.busy  = 1'b1;
            next_st.state = S_SLAVE;
            next_st.crc   = CRC_INIT;
            next_st.ptr   = {4'h0, st.loc_off};
            // float applies to 6/16 at or above base
            next_st.float_act = st.float_en && st.float_base <= st.start &&
                                (st.func == FC_WR_REG || st.func == FC_WR_REGS);
            if (fc_single)
              next_st.vcnt = 16'd1;
            else if (st.func == FC_WR_COILS)
              next_st.vcnt = (st.qty + 16'd7) >> 3;
            else
              next_st.vcnt = st.qty;
          end
        end
      end
      S_SLAVE: begin go = slot; bval = st.slave; if (slot) next_st.state = S_FUNC; end
      S_FUNC:  begin go = slot; bval = st.func;  if (slot) next_st.state = S_AH; end
      S_AH:    begin go = slot; bval = st.start[15:8]; if (slot) next_st.state = S_AL; end
      S_AL:
      begin
        go   = slot;
        bval = st.start[7:0];
        if (slot)
          next_st.state = fc_single ? S_RD0 : S_QH;
      end
      S_QH:    begin go = slot; bval = st.qty[15:8]; if (slot) next_st.state = S_QL; end
      S_QL:
      begin
        go   = slot;
        bval = st.qty[7:0];
        if (slot)
          next_st.state = fc_read ? S_CRCL : S_BC;
      end
      S_BC:    begin go = slot; bval = bc_calc; if (slot) next_st.state = S_RD0; end
      S_RD0:
      begin
        next_st.rd_addr = fc_bit ? st.ptr[AW+3:4] : st.ptr[AW-1:0];
        next_st.state   = S_RD1;
      end
      S_RD1:   begin next_st.rd_addr = st.rd_addr + 1'b1; next_st.state = S_RD2; end
      S_RD2:   begin next_st.w0 = rd_data; next_st.state = S_RD3; end
      S_RD3:
      begin
        next_st.w1    = rd_data;
        next_st.bidx  = 2'd0;
        next_st.state = S_DATA;
      end
      S_DATA:
      begin
        go = slot;
        case (st.bidx)
          2'd0:    bval = val32[31:24];
          2'd1:    bval = val32[23:16];
          2'd2:    bval = val32[15:8];
          default: bval = val32[7:0];
        endcase
        if (slot)
        begin
          next_st.bidx = st.bidx + 2'd1;
          if (st.bidx == nb_last)
          begin
            next_st.vcnt  = st.vcnt - 16'd1;
            next_st.state = (st.vcnt == 16'd1) ? S_CRCL : S_RD0;
            if (fc_bit)
              next_st.ptr = st.ptr + 20'd8;
            else
              next_st.ptr = st.ptr + (st.float_act ? 20'd2 : 20'd1);
          end
        end
      end
      S_CRCL:
      begin
        if (slot)
        begin
          next_st.tx_data  = st.crc[7:0];
          next_st.tx_valid = 1'b1;
          next_st.state    = S_CRCH;
        end
      end
      S_CRCH:
      begin
        if (slot)
        begin
          next_st.tx_data  = st.crc[15:8];
          next_st.tx_valid = 1'b1;
          next_st.tx_last  = 1'b1;
          next_st.busy     = 1'b0;
          next_st.state    = S_IDLE;
          next_st.poll_cnt = st.poll_ms;
          next_st.div      = DIV_TOP;
          next_st.pending  = next_st.pending || st.cont;
        end
      end
      default: next_st.state = S_IDLE;
    endcase

    if (go)
    begin
      next_st.tx_data  = bval;
      next_st.tx_valid = 1'b1;
      next_st.crc      = crc_upd(st.crc, bval);
    end

    // response check: zero residue means good
    if (rx_valid)
      next_st.rx_crc = crc_upd(st.rx_crc, rx_data);
    if (rx_end)
    begin
      next_st.rx_crc = CRC_INIT;
      if (st.rx_crc == 16'h0000)
        next_st.rx_ok = 1'b1;
      else
        next_st.rx_bad = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st            <= '0;
      st.state      <= S_IDLE;
      st.qty        <= QTY_RST;
      st.float_base <= FLT_BASE_RST;
      st.poll_ms    <= POLL_RST;
      st.crc        <= CRC_INIT;
      st.rx_crc     <= CRC_INIT;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign tx_data    = st.tx_data;
  assign tx_valid   = st.tx_valid;
  assign tx_last    = st.tx_last;
  assign frame_busy = st.busy;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence crc_low_sent;
    st.state == S_CRCL && slot;
  endsequence

  sequence frame_tail;
    ##1 (st.tx_valid && !st.tx_last) ##[1:300] (st.tx_valid && st.tx_last);
  endsequence

  a_fc_legal: assert property (st.busy |-> fc_legal)
    else $error("illegal function code in frame");
  a_addr_hi: assert property (st.state == S_AH && slot |=> st.tx_data == st.start[15:8])
    else $error("start address high byte wrong");
  a_float_bc: assert property (st.state == S_BC && slot && st.float_act
    |=> st.tx_data == 8'($past(st.qty) << 2))
    else $error("float byte count not doubled");
  a_plain_bc: assert property (st.state == S_BC && slot && !st.float_act && !fc_bit
    |=> st.tx_data == 8'($past(st.qty) << 1))
    else $error("plain byte count wrong");
  a_float_gate: assert property (st.float_act && st.busy
    |-> (st.func == FC_WR_REG || st.func == FC_WR_REGS))
    else $error("float handling on wrong code");
  a_qty_limit: assert property (st.busy && !fc_single
    |-> st.qty <= (fc_bit ? MAX_BITS : MAX_WORDS))
    else $error("quantity over limit");
  a_poll_gap: assert property (st.state == S_CRCH && slot && st.poll_ms != 16'd0
    |=> !st.busy [*2])
    else $error("command reissued inside poll gap");
  a_crc_tail: assert property (crc_low_sent |-> frame_tail)
    else $error("crc bytes not closing frame");
  a_word_swap: assert property (st.state == S_DATA && slot && st.float_act
    && st.bidx == 2'd0 && st.swap == 2'd1 |=> st.tx_data == st.w1[15:8])
    else $error("word swap order wrong");

endmodule : mbf_framer
`default_nettype wire

// File: mbf_pkg.sv
// Constants and types shared by the request framer and its testbench
package mbf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_NODE_FUNC = 8'h04;
  localparam logic [7:0] OFS_START     = 8'h08;
  localparam logic [7:0] OFS_QTY       = 8'h0c;
  localparam logic [7:0] OFS_LOC_OFF   = 8'h10;
  localparam logic [7:0] OFS_FLT_BASE  = 8'h14;
  localparam logic [7:0] OFS_POLL      = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1c;
  localparam logic [7:0] OFS_TBL_IDX   = 8'h20;
  localparam logic [7:0] OFS_TBL_DATA  = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CONT_BIT  = 1;
  localparam int CTRL_FLT_BIT   = 4;
  localparam int CTRL_SWAP_LSB  = 8;
  localparam int NF_FUNC_LSB    = 8;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_EFUNC_BIT   = 1;
  localparam int ST_EQTY_BIT    = 2;
  localparam int ST_RXOK_BIT    = 3;
  localparam int ST_RXBAD_BIT   = 4;

  // ----------------------------------------------------------------
  // Reset values and protocol figures
  // ----------------------------------------------------------------
  localparam logic [15:0] FLT_ADDR_ABOVE = 16'd7000;
  localparam logic [15:0] FLT_BASE_RST   = FLT_ADDR_ABOVE + 16'd1;
  localparam logic [15:0] POLL_RST       = 16'd0;
  localparam logic [15:0] QTY_RST        = 16'd1;
  localparam logic [15:0] MAX_WORDS      = 16'd125;
  localparam logic [15:0] MAX_BITS       = 16'd800;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  localparam logic [15:0] COIL_ON        = 16'hff00;

  // Function codes
  localparam logic [7:0] FC_RD_COIL  = 8'h01;
  localparam logic [7:0] FC_RD_INP   = 8'h02;
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_IREG  = 8'h04;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int POLL_UNIT_US  = 1000;
  localparam int CYC_PER_MS    = POLL_UNIT_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    S_IDLE, S_SLAVE, S_FUNC, S_AH, S_AL, S_QH, S_QL, S_BC,
    S_RD0, S_RD1, S_RD2, S_RD3, S_DATA, S_CRCL, S_CRCH
  } mbf_state_e;

endpackage : mbf_pkg

// File: mbf_table_ram.sv
// Local data table: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module mbf_table_ram #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : mbf_table_ram
`default_nettype wire

// File: mbf_slave_model.sv
// Remote slave model: collects request bytes, sends response bytes
`timescale 1ns/1ps
`default_nettype none
module mbf_slave_model (
  // Clock and pacing
  input  wire logic       pclk,
  input  wire logic       slow,
  // Request stream
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output var  logic       tx_ready,
  // Response stream
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  output var  logic       rx_end
);
  logic [7:0] frm [$];
  logic       done;
  logic [1:0] ph;

  initial
  begin
    tx_ready = 1'b0;
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_end   = 1'b0;
    done     = 1'b0;
    ph       = 2'd0;
  end

  always @(posedge pclk)
  begin
    ph       <= ph + 2'd1;
    tx_ready <= !slow || ph[1];
    if (tx_valid && tx_ready)
    begin
      frm.push_back(tx_data);
      if (tx_last)
        done <= 1'b1;
    end
  end

  // Response bytes, data line inverted once released
  task automatic reply(input logic [7:0] b [$]);
    foreach (b[i])
    begin
      @(posedge pclk);
      rx_data  <= b[i];
      rx_valid <= 1'b1;
    end
    @(posedge pclk);
    rx_data  <= ~rx_data;
    rx_valid <= 1'b0;
    rx_end   <= 1'b1;
    @(posedge pclk);
    rx_end   <= 1'b0;
  endtask : reply
endmodule : mbf_slave_model
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the request framer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mbf_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_last;
  logic        tx_ready;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_end;
  logic        frame_busy;
  logic        slow;
  logic [31:0] rv;
  logic        ev;
  int          failures;
  int          tests_run;
  int          idle_run = 0;
  int          last_gap = 0;

  mbf_framer #(.AW(10), .CYC_PER_MS(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_data, .tx_valid, .tx_last,
    .tx_ready, .rx_data, .rx_valid, .rx_end, .frame_busy);
  mbf_slave_model slave (.pclk, .slow, .tx_data, .tx_valid, .tx_last, .tx_ready,
    .rx_data, .rx_valid, .rx_end);

  // Idle cycles between two frames
  always @(posedge pclk)
  begin
    idle_run <= frame_busy ? 0 : idle_run + 1;
    if (frame_busy && idle_run != 0)
      last_gap <= idle_run;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic tmo;
    failures++;
    complete_run();
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [15:0] crc16(input logic [7:0] q [$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 50 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (n == 50)
      tmo();
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame(input logic [31:0] ctl, input logic [15:0] nf, input logic [15:0] sa,
                       input logic [15:0] q, input logic [7:0] e [$]);
    logic [15:0] c;
    int          n;
    apb(1'b1, OFS_NODE_FUNC, {16'h0, nf});
    apb(1'b1, OFS_START, {16'h0, sa});
    apb(1'b1, OFS_QTY, {16'h0, q});
    apb(1'b1, OFS_CTRL, ctl | 32'h1);
    for (n = 0; n < 3000 && !(slave.done && !frame_busy); n++)
      @(posedge pclk);
    if (n == 3000)
      tmo();
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    chk("frame length", slave.frm.size(), e.size());
    foreach (e[i])
      chk("frame byte", slave.frm[i], e[i]);
    slave.frm.delete();
    slave.done = 1'b0;
  endtask : frame

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, OFS_FLT_BASE, 32'h0);
    chk("float base", rv, 32'h1b59);
    apb(1'b0, OFS_POLL, 32'h0);
    chk("poll", rv, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, ev}, 32'h1);
  endtask : t_reset

  task automatic t_float;
    apb(1'b1, OFS_TBL_IDX, 32'h0);
    apb(1'b1, OFS_TBL_DATA, 32'hbd71);
    apb(1'b1, OFS_TBL_DATA, 32'h42aa);
    apb(1'b1, OFS_TBL_DATA, 32'he148);
    apb(1'b1, OFS_TBL_DATA, 32'h41b6);
    apb(1'b1, OFS_LOC_OFF, 32'h0);
    slow <= 1'b1;
    frame(32'h10, 16'h1001, 16'h1bbc, 16'h2, '{8'h01, 8'h10, 8'h1b, 8'hbc, 8'h00, 8'h02,
          8'h08, 8'hbd, 8'h71, 8'h42, 8'haa, 8'he1, 8'h48, 8'h41, 8'hb6});
    slow <= 1'b0;
  endtask : t_float

  task automatic t_plain;
    apb(1'b1, OFS_FLT_BASE, 32'h1c20);
    frame(32'h10, 16'h1001, 16'h1bbc, 16'h2, '{8'h01, 8'h10, 8'h1b, 8'hbc, 8'h00, 8'h02,
          8'h04, 8'hbd, 8'h71, 8'h42, 8'haa});
    frame(32'h210, 16'h1001, 16'h1bbc, 16'h2, '{8'h01, 8'h10, 8'h1b, 8'hbc, 8'h00, 8'h02,
          8'h04, 8'h71, 8'hbd, 8'haa, 8'h42});
    frame(32'h0, 16'h0501, 16'h0010, 16'h1, '{8'h01, 8'h05, 8'h00, 8'h10,
          8'hff, 8'h00});
    frame(32'h0, 16'h0f01, 16'h0010, 16'd10, '{8'h01, 8'h0f, 8'h00, 8'h10, 8'h00, 8'h0a,
          8'h02, 8'h71, 8'hbd});
    apb(1'b1, OFS_FLT_BASE, 32'h1b59);
  endtask : t_plain

  task automatic t_swap;
    logic [31:0] x [4] = '{32'he14841b6, 32'h41b6e148, 32'hb64148e1, 32'h48e1b641};
    apb(1'b1, OFS_LOC_OFF, 32'h2);
    for (int s = 0; s < 4; s++)
      frame(32'h10 | (s << 8), 16'h0601, 16'h1bbc, 16'h1, '{8'h01, 8'h06, 8'h1b, 8'hbc,
            x[s][31:24], x[s][23:16], x[s][15:8], x[s][7:0]});
  endtask : t_swap

  task automatic t_reads;
    logic [7:0]  r [$];
    logic [15:0] c;
    for (int f = 1; f < 5; f++)
      frame(32'h0, {f[7:0], 8'h01}, 16'h17d4, 16'h2,
            '{8'h01, f[7:0], 8'h17, 8'hd4, 8'h00, 8'h02});
    r = '{8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h42, 8'h03};
    c = crc16(r);
    r.push_back(c[7:0]);
    r.push_back(c[15:8]);
    slave.reply(r);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("rx good", rv[4:3], 2'b01);
    apb(1'b1, OFS_STATUS, 32'h18);
    r[8] = ~r[8];
    slave.reply(r);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("rx bad", rv[4:3], 2'b10);
    apb(1'b1, OFS_STATUS, 32'h18);
  endtask : t_reads

  task automatic t_poll;
    int n;
    apb(1'b1, OFS_POLL, 32'h2);
    frame(32'h2, 16'h0301, 16'h17d4, 16'h2,
          '{8'h01, 8'h03, 8'h17, 8'hd4, 8'h00, 8'h02});
    apb(1'b1, OFS_CTRL, 32'h0);
    for (n = 0; n < 3000 && !(slave.done && !frame_busy); n++)
      @(posedge pclk);
    if (n == 3000)
      tmo();
    chk("poll gap", {31'h0, last_gap >= 8}, 32'h1);
    chk("repeat length", slave.frm.size(), 32'd8);
    slave.frm.delete();
    slave.done = 1'b0;
    apb(1'b1, OFS_POLL, 32'h0);
  endtask : t_poll

  task automatic t_errors;
    logic [15:0] fq [3] = '{16'h0701, 16'h0301, 16'h0101};
    logic [15:0] qq [3] = '{16'd1, 16'd126, 16'd801};
    logic [1:0]  eb [3] = '{2'b01, 2'b10, 2'b10};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, OFS_NODE_FUNC, {16'h0, fq[i]});
      apb(1'b1, OFS_QTY, {16'h0, qq[i]});
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("refused flags", rv[2:1], eb[i]);
      chk("no frame", slave.frm.size(), 32'h0);
      apb(1'b1, OFS_STATUS, 32'h6);
    end
  endtask : t_errors

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever
      #25 pclk = ~pclk;
  end

  initial
  begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    slow      = 1'b0;
    failures  = 0;
    tests_run = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_float();
    t_plain();
    t_swap();
    t_reads();
    t_poll();
    t_errors();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
